// ===== design/adc_channel_select_power_ctrl.sv
// Digital control of an eight-input 10-bit converter behind a serial link.
// Assumes the host frames transfers with chip select and sends multiples
// of 16 serial clocks; sample results arrive from the analog core.
`default_nettype none
module adc_channel_select_power_ctrl
  import adc_ctrl_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Serial link, clocked by the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Analog core
  input wire logic [9:0] sample_code_i,
  output logic [2:0] chan_sel_o,
  output logic core_power_up_o,
  output logic core_track_o,
  // Core-side status
  output logic [2:0] active_chan_o,
  output logic frame_active_o
);
  // ------------------------------------------------------------------
  // Link domain: edge counting and control byte capture
  // ------------------------------------------------------------------
  // Select high acts as the framing reset of the link logic other than the
  // channel register; the link clock may stand still outside frames.
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_cnt_next;
  logic [7:0] ctrl_sr_reg;
  logic [7:0] ctrl_sr_next;
  logic [2:0] next_chan_reg;
  logic [2:0] next_chan_next;

  always_comb begin
    rise_cnt_next = rise_cnt_reg + 4'h1;
    ctrl_sr_next = ctrl_sr_reg;
    next_chan_next = next_chan_reg;
    if (rise_cnt_reg < 4'(ADDR_CYCLES)) begin
      ctrl_sr_next = {ctrl_sr_reg[6:0], din_i};
    end
    if (rise_cnt_reg == 4'(ADDR_CYCLES - 1)) begin
      next_chan_next = {ctrl_sr_reg[CHAN_SEL_BIT_HI - 1],
                        ctrl_sr_reg[CHAN_SEL_BIT_MID - 1],
                        ctrl_sr_reg[CHAN_SEL_BIT_LO - 1]};
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rise_cnt_reg <= EDGE_RESET;
      ctrl_sr_reg <= 8'h00;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      ctrl_sr_reg <= ctrl_sr_next;
    end
  end

  // Channel choice survives between frames; only core reset clears it.
  logic link_rst;
  adc_sync2 u_link_rst (
    .clk_i(sclk_i),
    .reset_i(1'b0),
    .d_i(reset_i),
    .q_o(link_rst)
  );

  always_ff @(posedge sclk_i) begin
    if (link_rst) begin
      next_chan_reg <= CHAN_RESET;
    end else if (!cs_n_i) begin
      next_chan_reg <= next_chan_next;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: falling-edge output and power state
  // ------------------------------------------------------------------
  // Falling edge count 1..15, then 0 for edge 16. Limitation: a select
  // that falls while the clock is low is not counted as edge 1; the
  // first real falling edge is.
  logic [3:0] fall_cnt_reg;
  logic [3:0] fall_cnt_next;
  logic [2:0] cur_chan_reg;
  logic [2:0] cur_chan_next;
  logic [9:0] result_sr_reg;
  logic [9:0] result_sr_next;
  logic dout_reg;
  logic dout_next;
  pwr_state_t pwr_reg;
  pwr_state_t pwr_next;
  logic oe_reg;
  logic oe_next;
  logic up_reg;
  logic up_next;
  logic track_reg;
  logic track_next;
  logic conv_reg;
  logic conv_next;

  always_comb begin
    fall_cnt_next = (fall_cnt_reg == 4'(FRAME_CYCLES)) ? 4'h1 :
                    fall_cnt_reg + 4'h1;
    cur_chan_next = cur_chan_reg;
    result_sr_next = result_sr_reg;
    dout_next = 1'b0;
    pwr_next = pwr_reg;
    if (fall_cnt_next == 4'h1) begin
      cur_chan_next = next_chan_reg;
    end
    if (fall_cnt_next == 4'(TRACK_CYCLES + 1)) begin
      result_sr_next = sample_code_i;
    end
    if (fall_cnt_next >= 4'(RESULT_FIRST) &&
        fall_cnt_next <= 4'(RESULT_LAST)) begin
      dout_next = result_sr_reg[RESULT_W - 1];
      result_sr_next = {result_sr_reg[8:0], 1'b0};
    end
    if (fall_cnt_next == 4'(FRAME_CYCLES)) begin
      pwr_next = PWR_DOWN;
    end else if (fall_cnt_next <= 4'(TRACK_CYCLES)) begin
      pwr_next = PWR_TRACK;
    end else begin
      pwr_next = PWR_CONVERT;
    end
    // Pin-facing outputs get flops of their own, quiet outside frames
    oe_next = 1'b1;
    up_next = (pwr_next != PWR_DOWN);
    track_next = (pwr_next == PWR_TRACK);
    conv_next = (pwr_next == PWR_CONVERT);
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fall_cnt_reg <= EDGE_RESET;
      cur_chan_reg <= CHAN_RESET;
      result_sr_reg <= RESULT_RESET;
      dout_reg <= 1'b0;
      pwr_reg <= PWR_DOWN;
      oe_reg <= 1'b0;
      up_reg <= 1'b0;
      track_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      fall_cnt_reg <= fall_cnt_next;
      cur_chan_reg <= cur_chan_next;
      result_sr_reg <= result_sr_next;
      dout_reg <= dout_next;
      pwr_reg <= pwr_next;
      oe_reg <= oe_next;
      up_reg <= up_next;
      track_reg <= track_next;
      conv_reg <= conv_next;
    end
  end

  assign dout_o = dout_reg;
  assign dout_oe_o = oe_reg;
  assign chan_sel_o = cur_chan_reg;
  assign core_power_up_o = up_reg;
  assign core_track_o = track_reg;

  // ------------------------------------------------------------------
  // Core domain status
  // ------------------------------------------------------------------
  // Channel word crosses as held data: only the converting-phase flag is
  // synchronised. The channel was set three link clocks before that
  // phase and stands for far longer than the synchroniser delay, so the
  // word is settled when taken; bitwise copies could show a torn value.
  logic conv_sync;
  logic frame_sync;

  adc_sync2 u_conv_sync (
    .clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(conv_reg),
    .q_o(conv_sync)
  );

  adc_sync2 u_frame_sync (
    .clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(~cs_n_i),
    .q_o(frame_sync)
  );

  logic [2:0] active_chan_reg;
  logic [2:0] active_chan_next;
  logic conv_seen_reg;
  logic conv_seen_next;
  logic frame_reg;
  logic frame_next;

  always_comb begin
    active_chan_next = active_chan_reg;
    conv_seen_next = conv_sync;
    frame_next = frame_sync;
    if (conv_sync && !conv_seen_reg) begin
      active_chan_next = cur_chan_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      active_chan_reg <= CHAN_RESET;
      conv_seen_reg <= 1'b0;
      frame_reg <= 1'b0;
    end else begin
      active_chan_reg <= active_chan_next;
      conv_seen_reg <= conv_seen_next;
      frame_reg <= frame_next;
    end
  end

  assign active_chan_o = active_chan_reg;
  assign frame_active_o = frame_reg;
endmodule // adc_channel_select_power_ctrl
`default_nettype wire

// ===== design/adc_sync2.sv
// Two-flop synchroniser for a single level.
// Assumes the input is asynchronous to clk_i.
`default_nettype none
module adc_sync2 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule // adc_sync2
`default_nettype wire

// ===== inc/adc_ctrl_pkg.sv
// Package: constants for the eight-channel converter control block.
// Assumes a 125 MHz core clock and a separate serial link clock.
`default_nettype none
package adc_ctrl_pkg;
  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int unsigned FRAME_CYCLES = 16;
  localparam int unsigned ADDR_CYCLES = 8;
  localparam int unsigned RESULT_FIRST = 5;
  localparam int unsigned RESULT_LAST = 14;
  localparam int unsigned TRACK_CYCLES = 3;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CHAN_W = 3;
  // Control byte field positions
  localparam int unsigned CHAN_SEL_BIT_HI = 5;
  localparam int unsigned CHAN_SEL_BIT_MID = 4;
  localparam int unsigned CHAN_SEL_BIT_LO = 3;
  // Reset values
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [3:0] EDGE_RESET = 4'h0;
  // Transfer function: step = supply / 1024, first edge at supply / 2048
  localparam int unsigned CODE_STEPS = 1024;
  localparam int unsigned FIRST_EDGE_DIV = 2048;
  // Power state of the converter core
  typedef enum logic [2:0] {
    PWR_DOWN = 3'b001,
    PWR_TRACK = 3'b010,
    PWR_CONVERT = 3'b100
  } pwr_state_t;
endpackage
`default_nettype wire

// ===== verif/adc_ctrl_chk_sva.sv
// Checker: link framing, output timing and power of the converter control.
// Assumes sclk idles high outside frames and stops there.
`default_nettype none
module adc_ctrl_chk (
  // Clocks and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  // Link and core outputs
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic [9:0] sample_code_i,
  input wire logic core_power_up_o,
  input wire logic core_track_o,
  input wire logic frame_active_o
);
  logic [4:0] fall_reg;
  logic [9:0] cap_reg;
  // Falling edge number in the conversion
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fall_reg <= 5'h00;
      cap_reg <= 10'h000;
    end else begin
      fall_reg <= (fall_reg == 5'h10) ? 5'h01 : fall_reg + 5'h01;
      if (fall_reg == 5'h03) cap_reg <= sample_code_i;
    end
  end
  a_oe_frame: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg != 5'h00 |-> dout_oe_o) else $error("oe low in frame");
  a_pwr_conv: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg inside {[1:15]} |-> core_power_up_o) else $error("pwr low");
  a_pwr_gap: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg == 5'h10 |-> !core_power_up_o) else $error("pwr in gap");
  a_track_phase: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg != 5'h00 |-> core_track_o == (fall_reg inside {[1:3]}))
    else $error("track phase");
  a_pad_zero: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg inside {[1:4], 15, 16} |-> !dout_o) else $error("pad bit");
  a_result_bit: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    fall_reg inside {[5:14]} |-> dout_o == cap_reg[14 - fall_reg])
    else $error("result bit");
  a_oe_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cs_n_i |-> !dout_oe_o) else $error("oe while idle");
  a_pwr_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cs_n_i |-> !core_power_up_o) else $error("pwr while idle");
  a_frame_flag: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !cs_n_i [*5] |=> frame_active_o) else $error("frame flag");
endmodule // adc_ctrl_chk
bind adc_channel_select_power_ctrl adc_ctrl_chk chk_u (.core_clk_i,
  .reset_i, .sclk_i, .cs_n_i, .dout_o, .dout_oe_o, .sample_code_i,
  .core_power_up_o, .core_track_o, .frame_active_o);
`default_nettype wire

// ===== verif/adc_host_model.sv
// Host serial controller model that frames conversions on the link.
// Assumes dout is read on sclk rising edges.
`default_nettype none
module adc_host_model (
  // Link
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Edges with select high; the channel register takes core reset only on them
  task automatic tick(input int n);
    repeat (n) begin
      #6 sclk_o = 1'b0;
      #6 sclk_o = 1'b1;
    end
  endtask
  task automatic conv(input logic [7:0] ctl, output logic [9:0] res);
    for (int i = 1; i <= 16; i++) begin
      #6 sclk_o = 1'b0;
      din_o = (i <= 8) ? ctl[8 - i] : ~din_o;
      #6 sclk_o = 1'b1;
      if (i >= 5 && i <= 14) res[14 - i] = dout_i;
    end
  endtask
  task automatic open_frame();
    #6 cs_n_o = 1'b0;
  endtask
  // Long idle gap with the clock stopped saves power
  task automatic close_frame();
    #6 cs_n_o = 1'b1;
    #60;
  endtask
endmodule // adc_host_model
`default_nettype wire

// ===== verif/test_adc_channel_select_power_ctrl.sv
// Testbench: channel sweep, result codes and power framing.
// Assumes the host model drives the link at a 12 ns period.
`default_nettype none
module test_adc_channel_select_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] sample_code_i = 10'h000;
  logic sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, dout_w, tog_reg = 1'b0;
  logic [2:0] chan_sel_o, active_chan_o;
  logic core_power_up_o, core_track_o, frame_active_o;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  always #4 core_clk_i = ~core_clk_i;
  // Released line changes every cycle, never shows a stale bit
  always @(posedge core_clk_i) tog_reg <= ~tog_reg;
  assign dout_w = dout_oe_o ? dout_o : tog_reg;
  adc_channel_select_power_ctrl dut_u (.core_clk_i, .reset_i, .sclk_i,
    .cs_n_i, .din_i, .dout_o, .dout_oe_o, .sample_code_i, .chan_sel_o,
    .core_power_up_o, .core_track_o, .active_chan_o, .frame_active_o);
  adc_host_model host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
    .dout_i(dout_w));
  task automatic chk(input string nm, input logic [9:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end
  // Nine back-to-back conversions; don't-care bits set
  task automatic t_chan();
    logic [9:0] res;
    host_u.open_frame();
    for (int k = 0; k <= 8; k++) begin
      host_u.conv(8'hc7 | 8'(k << 3), res);
      chk("chan", 10'(chan_sel_o), (k == 0) ? 10'h000 : 10'(k - 1));
      chk("pwr gap", 10'(core_power_up_o), 10'h000);
    end
    host_u.close_frame();
    chk("core chan", 10'(active_chan_o), 10'h007);
    $display("test chan done");
  endtask
  // Ideal core transfer: step is full scale over 1024, first edge half
  function automatic logic [9:0] code_of(input longint uv, input longint fs);
    longint c;
    c = (uv * adc_ctrl_pkg::FIRST_EDGE_DIV / fs + 1) / 2;
    if (c > adc_ctrl_pkg::CODE_STEPS - 1) c = adc_ctrl_pkg::CODE_STEPS - 1;
    return 10'(c);
  endfunction
  // Boundary codes through the ideal transfer, one conversion per frame
  task automatic t_code();
    logic [9:0] res;
    longint uv [5] = '{0, 999, 1000, 2048000, 1354000};
    logic [9:0] codes [5] = '{10'h000, 10'h000, 10'h001, 10'h3ff, 10'h2a5};
    foreach (codes[i]) begin
      @(posedge core_clk_i) #1 sample_code_i = code_of(uv[i], 2048000);
      host_u.open_frame();
      host_u.conv(8'h00, res);
      chk("result", res, codes[i]);
      host_u.close_frame();
      chk("oe idle", 10'(dout_oe_o), 10'h000);
      chk("pwr idle", 10'(core_power_up_o), 10'h000);
      chk("track idle", 10'(core_track_o), 10'h000);
    end
    chk("frame flag", 10'(frame_active_o), 10'h000);
    $display("test code done");
  endtask
  initial begin
    fork host_u.tick(4); join_none
    repeat (20) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    t_chan();
    t_code();
    test_done();
  end
endmodule // test_adc_channel_select_power_ctrl
`default_nettype wire
